// ### lsf_flags.sv
`timescale 1ns/1ps
// Notes on behaviour
// - 2.5 V and supply faults latch bits 0, 2
// - Temperature faults latch primary bits 4, 5, 6
// - Read clears flag only if fault gone
// - Primary bit 7 ORs all secondary bits
// - Overheat bit clears below limit minus hysteresis
// - Secondary bits 2-4 flag slow fans one-three
// - Fan flags suppressed while drive output off
// - Bit 5 flags fan four, gated by third drive
// - Timer mode: bit 5 flags overheat time exceeded
// - Bits 6, 7 flag remote diode open/short
// - Primary register at 0x41, resets 0x00, read-only
// - Secondary register at 0x42, resets 0x00, read-only
// - Configuration lock leaves voltage limits writable
// - High fault only when reading exceeds ceiling
// - Low fault when reading at or below floor
// - Speed_pulse_input count above minimum means slow fan
// - Minimum 0xFFFF or 0x0000 disables fan flag
module lsf_flags #(
	parameter int FANS = 4,
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Register port from the serial bus engine
	input wire lsf_pkg::lsf_req_t REQ,
	output logic [7:0] RDATA,
	// Voltage readings
	input wire logic [7:0] LOW_RAIL_READING,
	input wire logic [7:0] SUPPLY_READING,
	// Temperature faults: remote one, local, remote two
	input wire logic [2:0] TEMP_FAULT,
	// Overheat pin limit exceeded, and temperature below limit minus hysteresis
	input wire logic OVERHEAT_ACTIVE,
	input wire logic OVERHEAT_RELEASED,
	// Shared pin in overheat timer mode, and time limit exceeded
	input wire logic TIMER_MODE,
	input wire logic OVERTIME,
	// Fan speed_pulse_input counts, minimums, and drive outputs on (three drives)
	input wire logic [FANS*CW-1:0] SPEED_PULSE_INPUT_COUNT,
	input wire logic [FANS*CW-1:0] SPEED_PULSE_INPUT_MIN,
	input wire logic [2:0] DRIVE_ON,
	// Remote diode open or short
	input wire logic [1:0] DIODE_FAULT,
	// Flag state for other blocks
	output logic [7:0] PRIMARY_FLAGS,
	output logic [7:0] SECONDARY_FLAGS
);
	// Bit mapping of the secondary register is fixed to four fans
	if (FANS != 4 || CW < 1) begin : g_param_check
		$error("lsf_flags supports exactly four fans");
	end

	logic [7:0] low_rail_floor;
	logic [7:0] low_rail_ceiling;
	logic [7:0] supply_floor;
	logic [7:0] supply_ceiling;
	logic [7:0] primary;
	logic [7:0] secondary;
	logic [7:0] rdata;
	logic [7:0] next_low_rail_floor;
	logic [7:0] next_low_rail_ceiling;
	logic [7:0] next_supply_floor;
	logic [7:0] next_supply_ceiling;
	logic [7:0] next_primary;
	logic [7:0] next_secondary;
	logic [7:0] next_rdata;

	logic low_rail_fault;
	logic supply_fault;
	logic [FANS-1:0] fan_fault;
	logic [FANS-1:0] fan_drive;
	logic [7:0] p_cond;
	logic [7:0] s_cond;
	logic [7:0] s_release;
	logic rd_primary;
	logic rd_secondary;

	lsf_window #(.WIDTH(8)) u_low_rail (
		.reading(LOW_RAIL_READING),
		.floor_val(low_rail_floor),
		.ceiling_val(low_rail_ceiling),
		.fault(low_rail_fault)
	);

	lsf_window #(.WIDTH(8)) u_supply (
		.reading(SUPPLY_READING),
		.floor_val(supply_floor),
		.ceiling_val(supply_ceiling),
		.fault(supply_fault)
	);

	// Fourth fan shares the third drive output
	assign fan_drive = {DRIVE_ON[2], DRIVE_ON[2], DRIVE_ON[1], DRIVE_ON[0]};

	lsf_fan_check #(.FANS(FANS), .CW(CW)) u_fans (
		.count(SPEED_PULSE_INPUT_COUNT),
		.minimum(SPEED_PULSE_INPUT_MIN),
		.drive_on(fan_drive),
		.fault(fan_fault)
	);

	assign rd_primary = REQ.rd && (REQ.addr == lsf_pkg::ADDR_PRIMARY);
	assign rd_secondary = REQ.rd && (REQ.addr == lsf_pkg::ADDR_SECONDARY);

	// Present fault conditions per bit
	always_comb begin
		p_cond = 8'h00;
		p_cond[lsf_pkg::P_LOW_RAIL] = low_rail_fault;
		p_cond[lsf_pkg::P_SUPPLY] = supply_fault;
		p_cond[lsf_pkg::P_REMOTE_ONE] = TEMP_FAULT[0];
		p_cond[lsf_pkg::P_LOCAL] = TEMP_FAULT[1];
		p_cond[lsf_pkg::P_REMOTE_TWO] = TEMP_FAULT[2];
		s_cond = 8'h00;
		s_cond[lsf_pkg::S_OVERHEAT] = OVERHEAT_ACTIVE;
		s_cond[lsf_pkg::S_FAN_FIRST +: 3] = fan_fault[2:0];
		s_cond[lsf_pkg::S_FAN_FOURTH] = TIMER_MODE ? OVERTIME : fan_fault[3];
		s_cond[lsf_pkg::S_DIODE_ONE] = DIODE_FAULT[0];
		s_cond[lsf_pkg::S_DIODE_TWO] = DIODE_FAULT[1];
		// A read releases a bit only when its cause is gone
		s_release = ~s_cond;
		s_release[lsf_pkg::S_OVERHEAT] = OVERHEAT_RELEASED && !OVERHEAT_ACTIVE;
	end

	// Flags: set wins over the read clear
	always_comb begin
		logic [7:0] p_keep;
		logic [7:0] s_keep;
		p_keep = 8'h00;
		s_keep = 8'h00;
		p_keep = rd_primary ? (primary & p_cond) : primary;
		s_keep = rd_secondary ? (secondary & ~s_release) : secondary;
		next_secondary = (s_keep | s_cond) & lsf_pkg::SECONDARY_MASK;
		next_primary = (p_keep | p_cond) & lsf_pkg::PRIMARY_MASK;
		// Summary follows the secondary contents in the same cycle
		next_primary[lsf_pkg::P_SUMMARY] = |next_secondary;
	end

	// Voltage limit writes; lock has no bearing on them
	always_comb begin
		next_low_rail_floor = low_rail_floor;
		next_low_rail_ceiling = low_rail_ceiling;
		next_supply_floor = supply_floor;
		next_supply_ceiling = supply_ceiling;
		if (REQ.wr) begin
			unique case (REQ.addr)
				lsf_pkg::ADDR_LOW_RAIL_FLOOR: begin
					next_low_rail_floor = REQ.wdata;
				end
				lsf_pkg::ADDR_LOW_RAIL_CEILING: begin
					next_low_rail_ceiling = REQ.wdata;
				end
				lsf_pkg::ADDR_SUPPLY_FLOOR: begin
					next_supply_floor = REQ.wdata;
				end
				lsf_pkg::ADDR_SUPPLY_CEILING: begin
					next_supply_ceiling = REQ.wdata;
				end
				default: begin
					// Status registers and unmapped offsets ignore writes
					next_low_rail_floor = low_rail_floor;
				end
			endcase
		end
	end

	// Read data returns the value held before the read's clear
	always_comb begin
		next_rdata = rdata;
		if (REQ.rd) begin
			unique case (REQ.addr)
				lsf_pkg::ADDR_PRIMARY: begin
					next_rdata = primary;
				end
				lsf_pkg::ADDR_SECONDARY: begin
					next_rdata = secondary;
				end
				lsf_pkg::ADDR_LOW_RAIL_FLOOR: begin
					next_rdata = low_rail_floor;
				end
				lsf_pkg::ADDR_LOW_RAIL_CEILING: begin
					next_rdata = low_rail_ceiling;
				end
				lsf_pkg::ADDR_SUPPLY_FLOOR: begin
					next_rdata = supply_floor;
				end
				lsf_pkg::ADDR_SUPPLY_CEILING: begin
					next_rdata = supply_ceiling;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			primary <= lsf_pkg::RST_FLAGS;
			secondary <= lsf_pkg::RST_FLAGS;
			low_rail_floor <= lsf_pkg::RST_FLOOR;
			low_rail_ceiling <= lsf_pkg::RST_CEILING;
			supply_floor <= lsf_pkg::RST_FLOOR;
			supply_ceiling <= lsf_pkg::RST_CEILING;
			rdata <= lsf_pkg::RST_FLAGS;
		end else begin
			primary <= next_primary;
			secondary <= next_secondary;
			low_rail_floor <= next_low_rail_floor;
			low_rail_ceiling <= next_low_rail_ceiling;
			supply_floor <= next_supply_floor;
			supply_ceiling <= next_supply_ceiling;
			rdata <= next_rdata;
		end
	end

	assign RDATA = rdata;
	assign PRIMARY_FLAGS = primary;
	assign SECONDARY_FLAGS = secondary;
endmodule

// ### lsf_pkg.sv
package lsf_pkg;
	// Register offsets on the internal register port
	localparam logic [7:0] ADDR_PRIMARY = 8'h41;
	localparam logic [7:0] ADDR_SECONDARY = 8'h42;
	localparam logic [7:0] ADDR_LOW_RAIL_FLOOR = 8'h44;
	localparam logic [7:0] ADDR_LOW_RAIL_CEILING = 8'h45;
	localparam logic [7:0] ADDR_SUPPLY_FLOOR = 8'h48;
	localparam logic [7:0] ADDR_SUPPLY_CEILING = 8'h49;
	// Reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_FLOOR = 8'h00;
	localparam logic [7:0] RST_CEILING = 8'hFF;
	// Speed_pulse_input minimum values that disable the fan check
	localparam logic [15:0] SPEED_PULSE_INPUT_OFF_ALL_ONES = 16'hFFFF;
	localparam logic [15:0] SPEED_PULSE_INPUT_OFF_ZERO = 16'h0000;
	// Field positions, primary register
	localparam int P_LOW_RAIL = 0;
	localparam int P_SUPPLY = 2;
	localparam int P_REMOTE_ONE = 4;
	localparam int P_LOCAL = 5;
	localparam int P_REMOTE_TWO = 6;
	localparam int P_SUMMARY = 7;
	// Field positions, secondary register
	localparam int S_OVERHEAT = 1;
	localparam int S_FAN_FIRST = 2;
	localparam int S_FAN_FOURTH = 5;
	localparam int S_DIODE_ONE = 6;
	localparam int S_DIODE_TWO = 7;
	// Implemented bits; reserved bits read zero
	localparam logic [7:0] PRIMARY_MASK = 8'h75;
	localparam logic [7:0] SECONDARY_MASK = 8'hFE;

	// Register port request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lsf_req_t;

	// Fault conditions from the measurement engines, levels
	typedef struct packed {
		logic [1:0] temp_fault;      // remote one and remote two; local has its own field below
		logic local_fault;
		logic overheat_active;
		logic overheat_cleared;
		logic overtime;
		logic [1:0] diode_fault;
	} lsf_cond_t;
endpackage

// ### lsf_window.sv
`timescale 1ns/1ps
// Window compare of one reading against floor and ceiling
module lsf_window #(
	parameter int WIDTH = 8
) (
	// Reading and its limits
	input wire logic [WIDTH-1:0] reading,
	input wire logic [WIDTH-1:0] floor_val,
	input wire logic [WIDTH-1:0] ceiling_val,
	// Outside the window
	output logic fault
);
	always_comb begin
		fault = (reading > ceiling_val) || (reading <= floor_val);
	end
endmodule

// ### lsf_fan_check.sv
`timescale 1ns/1ps
// Slow or stalled fan detection for several speed_pulse_input channels
module lsf_fan_check #(
	parameter int FANS = 4,
	parameter int CW = 16
) (
	// Speed_pulse_input counts, minimums and drive gates
	input wire logic [FANS*CW-1:0] count,
	input wire logic [FANS*CW-1:0] minimum,
	input wire logic [FANS-1:0] drive_on,
	// Slow or stalled per fan
	output logic [FANS-1:0] fault
);
	for (genvar i = 0; i < FANS; i++) begin : g_fan
		logic [CW-1:0] c;
		logic [CW-1:0] m;
		logic check_on;
		assign c = count[i*CW +: CW];
		assign m = minimum[i*CW +: CW];
		assign check_on = (m != lsf_pkg::SPEED_PULSE_INPUT_OFF_ALL_ONES) && (m != lsf_pkg::SPEED_PULSE_INPUT_OFF_ZERO);
		// Larger count means a longer period, so a slower fan
		assign fault[i] = drive_on[i] && check_on && (c > m);
	end
endmodule

// ### lsf_flags_properties.sv
`timescale 1ns/1ps
module lsf_flags_properties #(
	parameter int FANS = 4,
	parameter int CW = 16
) (
	// Clock, reset, register port
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire lsf_pkg::lsf_req_t REQ,
	input wire logic [7:0] RDATA,
	// Fault sources
	input wire logic [7:0] LOW_RAIL_READING,
	input wire logic [7:0] SUPPLY_READING,
	input wire logic [2:0] TEMP_FAULT,
	input wire logic OVERHEAT_ACTIVE,
	input wire logic OVERHEAT_RELEASED,
	input wire logic TIMER_MODE,
	input wire logic OVERTIME,
	input wire logic [FANS*CW-1:0] SPEED_PULSE_INPUT_COUNT,
	input wire logic [FANS*CW-1:0] SPEED_PULSE_INPUT_MIN,
	input wire logic [2:0] DRIVE_ON,
	input wire logic [1:0] DIODE_FAULT,
	// Flag state
	input wire logic [7:0] PRIMARY_FLAGS,
	input wire logic [7:0] SECONDARY_FLAGS
);
	logic rd_p;
	assign rd_p = REQ.rd && REQ.addr == lsf_pkg::ADDR_PRIMARY;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// Data port shows the flags as they stood at the read edge
	sequence s_primary_answer;
		rd_p ##1 RDATA == $past(PRIMARY_FLAGS);
	endsequence
	a_summary_or: assert property (PRIMARY_FLAGS[7] == |SECONDARY_FLAGS)
		else $error("summary bit wrong");
	a_reserved_zero: assert property ({PRIMARY_FLAGS[3], PRIMARY_FLAGS[1], SECONDARY_FLAGS[0]} == 3'h0)
		else $error("reserved bit set");
	a_floor_equal: assert property (LOW_RAIL_READING == 8'h00 |=> PRIMARY_FLAGS[0])
		else $error("low rail fault missed");
	a_temp_latch: assert property (|TEMP_FAULT |=> (PRIMARY_FLAGS[6:4] & $past(TEMP_FAULT)) == $past(TEMP_FAULT))
		else $error("temperature fault missed");
	a_read_clears: assert property (rd_p && !TEMP_FAULT[1] |=> !PRIMARY_FLAGS[5])
		else $error("local flag not cleared");
	a_fan_gate: assert property (!DRIVE_ON[0] && !SECONDARY_FLAGS[2] |=> !SECONDARY_FLAGS[2])
		else $error("fan flag set while drive off");
	a_timer_flag: assert property (TIMER_MODE && OVERTIME |=> SECONDARY_FLAGS[5])
		else $error("overtime flag missed");
	a_read_data: assert property (rd_p |-> s_primary_answer)
		else $error("read data wrong");
endmodule
bind lsf_flags lsf_flags_properties #(.FANS(FANS), .CW(CW)) lsf_flags_properties_i (.CLK_SYS(CLK_SYS), .RST(RST),
	.REQ(REQ), .RDATA(RDATA), .LOW_RAIL_READING(LOW_RAIL_READING), .SUPPLY_READING(SUPPLY_READING),
	.TEMP_FAULT(TEMP_FAULT), .OVERHEAT_ACTIVE(OVERHEAT_ACTIVE), .OVERHEAT_RELEASED(OVERHEAT_RELEASED),
	.TIMER_MODE(TIMER_MODE), .OVERTIME(OVERTIME), .SPEED_PULSE_INPUT_COUNT(SPEED_PULSE_INPUT_COUNT), .SPEED_PULSE_INPUT_MIN(SPEED_PULSE_INPUT_MIN),
	.DRIVE_ON(DRIVE_ON), .DIODE_FAULT(DIODE_FAULT), .PRIMARY_FLAGS(PRIMARY_FLAGS),
	.SECONDARY_FLAGS(SECONDARY_FLAGS));

// ### lsf_host.sv
`timescale 1ns/1ps
module lsf_host (
	// Clock
	input wire logic clk,
	// Register port requests
	output lsf_pkg::lsf_req_t req
);
	initial req = '0;
	// Released lines show inverted values so a stale address is never mistaken for a live one
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		req <= '{rd: !w, wr: w, addr: a, wdata: d};
		@(negedge clk);
		req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
		@(negedge clk);
	endtask
endmodule

// ### limit_status_flags_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module limit_status_flags_tb;
	typedef struct packed {logic [7:0] low; logic [7:0] sup; logic [2:0] tf; logic [7:0] exp;} lsf_row_t;
	lsf_row_t rows [6] = '{'{8'h40, 8'h80, 3'h0, 8'h01}, '{8'h41, 8'hC0, 3'h0, 8'h00}, '{8'hC1, 8'h80, 3'h2, 8'h21},
		'{8'h80, 8'h40, 3'h0, 8'h04}, '{8'h80, 8'hC1, 3'h7, 8'h74}, '{8'h00, 8'hFF, 3'h0, 8'h05}};
	logic [7:0] reg_addr [6] = '{8'h41, 8'h42, 8'h44, 8'h45, 8'h48, 8'h49};
	logic [7:0] reg_rst [6] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF};
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	lsf_pkg::lsf_req_t REQ;
	logic [7:0] RDATA;
	logic [7:0] PRIMARY_FLAGS;
	logic [7:0] SECONDARY_FLAGS;
	logic [7:0] LOW_RAIL_READING = 8'h80;
	logic [7:0] SUPPLY_READING = 8'h80;
	logic [2:0] TEMP_FAULT = 3'h0;
	logic [2:0] DRIVE_ON = 3'h0;
	logic OVERHEAT_ACTIVE = 1'b0;
	logic OVERHEAT_RELEASED = 1'b1;
	logic TIMER_MODE = 1'b0;
	logic OVERTIME = 1'b0;
	logic [63:0] SPEED_PULSE_INPUT_COUNT = {4{16'h1001}};
	logic [63:0] SPEED_PULSE_INPUT_MIN = {16'h0000, {3{16'h1000}}};
	logic [1:0] DIODE_FAULT = 2'h0;
	int n_errors = 0;
	int check_count = 0;
	lsf_host lsf_host_i (.clk(CLK_SYS), .req(REQ));
	lsf_flags #(.FANS(4), .CW(16)) lsf_flags_i (.CLK_SYS(CLK_SYS), .RST(RST), .REQ(REQ), .RDATA(RDATA),
		.LOW_RAIL_READING(LOW_RAIL_READING), .SUPPLY_READING(SUPPLY_READING), .TEMP_FAULT(TEMP_FAULT),
		.OVERHEAT_ACTIVE(OVERHEAT_ACTIVE), .OVERHEAT_RELEASED(OVERHEAT_RELEASED), .TIMER_MODE(TIMER_MODE),
		.OVERTIME(OVERTIME), .SPEED_PULSE_INPUT_COUNT(SPEED_PULSE_INPUT_COUNT), .SPEED_PULSE_INPUT_MIN(SPEED_PULSE_INPUT_MIN), .DRIVE_ON(DRIVE_ON),
		.DIODE_FAULT(DIODE_FAULT), .PRIMARY_FLAGS(PRIMARY_FLAGS), .SECONDARY_FLAGS(SECONDARY_FLAGS));
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		lsf_host_i.acc(1'b0, a, 8'h00);
		`CHK(RDATA, e)
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		forever #5 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		repeat (5000) @(posedge CLK_SYS);
		n_errors++;
		$display("BAD %0t run too long", $time);
		end_of_test();
	end
	initial begin
		repeat (8) @(negedge CLK_SYS);
		RST = 1'b0;
		for (int i = 2; i < 6; i++) begin
			lsf_host_i.acc(1'b1, reg_addr[i], i[0] ? 8'hC0 : 8'h40);
		end
		// Each row: read with the fault present, remove it, read twice more
		foreach (rows[i]) begin
			{LOW_RAIL_READING, SUPPLY_READING, TEMP_FAULT} = rows[i][26:8];
			@(negedge CLK_SYS);
			`CHK(PRIMARY_FLAGS, rows[i].exp)
			rd(8'h41, rows[i].exp);
			{LOW_RAIL_READING, SUPPLY_READING, TEMP_FAULT} = {8'h80, 8'h80, 3'h0};
			rd(8'h41, rows[i].exp);
			rd(8'h41, 8'h00);
			`CHK(PRIMARY_FLAGS, 8'h00)
		end
		$display("limit rows done");
		DRIVE_ON = 3'h6;
		@(negedge CLK_SYS);
		`CHK(SECONDARY_FLAGS, 8'h18)
		`CHK(PRIMARY_FLAGS, 8'h80)
		rd(8'h42, 8'h18);
		rd(8'h41, 8'h80);
		{TIMER_MODE, OVERTIME, DRIVE_ON} = {1'b1, 1'b1, 3'h0};
		@(negedge CLK_SYS);
		rd(8'h42, 8'h38);
		OVERTIME = 1'b0;
		rd(8'h42, 8'h20);
		rd(8'h42, 8'h00);
		{TIMER_MODE, DRIVE_ON, SPEED_PULSE_INPUT_MIN} = {1'b0, 3'h4, {4{16'h1000}}};
		@(negedge CLK_SYS);
		rd(8'h42, 8'h30);
		DRIVE_ON = 3'h0;
		rd(8'h42, 8'h30);
		{OVERHEAT_ACTIVE, OVERHEAT_RELEASED, DIODE_FAULT} = {1'b1, 1'b0, 2'h3};
		@(negedge CLK_SYS);
		rd(8'h42, 8'hC2);
		{OVERHEAT_ACTIVE, DIODE_FAULT} = {1'b0, 2'h0};
		rd(8'h42, 8'hC2);
		rd(8'h42, 8'h02);
		OVERHEAT_RELEASED = 1'b1;
		rd(8'h42, 8'h02);
		rd(8'h42, 8'h00);
		`CHK(PRIMARY_FLAGS, 8'h00)
		$display("status bits done");
		RST = 1'b1;
		repeat (2) @(negedge CLK_SYS);
		RST = 1'b0;
		foreach (reg_addr[i]) begin
			rd(reg_addr[i], reg_rst[i]);
		end
		rd(8'h43, 8'h00);
		lsf_host_i.acc(1'b1, 8'h41, 8'hFF);
		rd(8'h41, 8'h00);
		lsf_host_i.acc(1'b1, 8'h44, 8'h5A);
		rd(8'h44, 8'h5A);
		$display("reset and access done");
		end_of_test();
	end
endmodule
